// *** rtl/ppfm_consts.vh ***
// constants for the port pin function multiplexer
`ifndef PPFM_CONSTS_VH
`define PPFM_CONSTS_VH
// apb byte offsets
`define PPFM_OFF_CROLE_LO 8'h00
`define PPFM_OFF_CROLE_HI 8'h04
`define PPFM_OFF_DROLE 8'h08
`define PPFM_OFF_ROUTE 8'h0C
`define PPFM_OFF_DATA_BASE 8'h10
`define PPFM_OFF_DIR_BASE 8'h20
`define PPFM_OFF_WAKE_EN 8'h30
`define PPFM_OFF_BITOP 8'h34
`define PPFM_OFF_WAKE_STAT 8'h38
// reset values
`define PPFM_RST_ROLE 8'h00
`define PPFM_RST_ROUTE 8'h00
`define PPFM_RST_PORT 8'hFF
`define PPFM_RST_WAKE 8'h00
// implemented bits of port c role and routing registers
`define PPFM_ROLE_MASK 8'h3F
`define PPFM_ROUTE_MASK_LARGE 8'h3F
`define PPFM_ROUTE_MASK_SMALL 8'h30
// routing bit positions
`define PPFM_RT_IRQ1 5
`define PPFM_RT_IRQ0 4
`define PPFM_RT_SDIN 3
`define PPFM_RT_SCLK 2
`define PPFM_RT_SSEL 1
`define PPFM_RT_URX 0
// role codes
`define PPFM_CODE_GPIO 2'h0
`define PPFM_CODE_ALT1 2'h1
`define PPFM_CODE_ALT2 2'h2
`define PPFM_CODE_ALT3 2'h3
// bit operation word fields
`define PPFM_BOP_PORT_LSB 0
`define PPFM_BOP_BIT_LSB 2
`define PPFM_BOP_TGT 5
`define PPFM_BOP_VAL 6
`endif

// *** rtl/ppfm_pin_cell.v ***
// one shared pin: picks general i/o or peripheral drive, registered
`timescale 1ns/100ps
module ppfm_pin_cell (
    input wire clk,
    input wire rst,
    input wire gpioOut,
    input wire gpioDirIn,
    input wire periphEn,
    input wire periphOut,
    input wire periphOe,
    output reg pinOut,
    output reg pinOe
);
    // peripheral replaces data and direction while its role is chosen
    always @(posedge clk) begin
        if (rst) begin
            pinOut <= 1'b1;
            pinOe <= 1'b0;
        end else if (periphEn) begin
            pinOut <= periphOut;
            pinOe <= periphOe;
        end else begin
            pinOut <= gpioOut;
            pinOe <= ~gpioDirIn;
        end
    end
endmodule // ppfm_pin_cell

// *** rtl/ppfm_top.v ***
// port pin function multiplexer with apb registers and port a wake-up
`timescale 1ns/100ps
`include "ppfm_consts.vh"
module ppfm_top #(
    parameter LARGE_VARIANT = 1
) (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] portAIn,
    input wire [7:0] portBIn,
    input wire [7:0] portCIn,
    input wire [7:0] portDIn,
    output reg [7:0] portAOut,
    output reg [7:0] portAOe,
    output reg [7:0] portBOut,
    output reg [7:0] portBOe,
    output wire [7:0] portCOut,
    output wire [7:0] portCOe,
    output reg [7:0] portDOut,
    output reg [7:0] portDOe,
    input wire uartTxOut,
    input wire uartTxOe,
    input wire serialDoutOut,
    input wire serialDoutOe,
    input wire serialClkOut,
    input wire serialClkOe,
    input wire serialDataOut,
    input wire serialDataOe,
    input wire serialSelectOut,
    input wire serialSelectOe,
    input wire [5:0] lcdComSeg,
    input wire lcdDriveOn,
    input wire lowPowerMode,
    output reg extIrq0,
    output reg extIrq1,
    output reg serialDinIn,
    output reg serialClkIn,
    output reg serialSelectIn,
    output reg uartRxIn,
    output reg externalResetInN,
    output reg crystalPinsSelected,
    output reg wakeRequest
);
    localparam [7:0] ROUTE_MASK = (LARGE_VARIANT != 0) ? `PPFM_ROUTE_MASK_LARGE
                                                       : `PPFM_ROUTE_MASK_SMALL;
    localparam [7:0] HI_MASK = (LARGE_VARIANT != 0) ? `PPFM_ROLE_MASK : 8'h00;

    reg [7:0] cRoleLo_reg;
    reg [7:0] cRoleHi_reg;
    reg [7:0] dRole_reg;
    reg [7:0] route_reg;
    reg [7:0] wakeEn_reg;
    reg [7:0] wakeStat_reg;
    reg [7:0] prevA_reg;
    reg [7:0] data_reg [0:3];
    reg [7:0] dir_reg [0:3];

    reg [31:0] rdata_next;
    reg decodeHit;
    reg [7:0] bopBase;
    reg [7:0] bopMask;
    reg [7:0] bopNew;
    reg [1:0] bopPort;
    reg [7:0] periphEn;
    reg [7:0] periphOut;
    reg [7:0] periphOe;
    reg [7:0] wakeFall;

    wire setup = psel & ~penable;
    wire wrTake = psel & penable & pready & pwrite;
    wire [1:0] roleC0 = cRoleLo_reg[1:0];
    wire [1:0] roleC1 = cRoleLo_reg[3:2];
    wire [1:0] roleC2 = cRoleLo_reg[5:4];
    wire [1:0] roleC4 = cRoleHi_reg[1:0];
    wire [1:0] roleC5 = cRoleHi_reg[3:2];
    wire [1:0] roleC6 = cRoleHi_reg[5:4];
    wire [7:0] wrByte = pwdata[7:0];
    wire [1:0] portIdx = paddr[3:2];
    wire isData = (paddr[7:4] == `PPFM_OFF_DATA_BASE >> 4);
    wire isDir = (paddr[7:4] == `PPFM_OFF_DIR_BASE >> 4);

    // pin level of a chosen port, as a bit operation reads it
    function [7:0] pinsOf;
        input [1:0] idx;
        input [7:0] a;
        input [7:0] b;
        input [7:0] c;
        input [7:0] d;
        begin
            case (idx)
                2'h0: pinsOf = a;
                2'h1: pinsOf = b;
                2'h2: pinsOf = c;
                default: pinsOf = d;
            endcase
        end
    endfunction

    // read decode for the access phase that follows this setup cycle
    always @* begin
        rdata_next = 32'h0000_0000;
        decodeHit = 1'b1;
        if (paddr == `PPFM_OFF_CROLE_LO) begin
            rdata_next[7:0] = cRoleLo_reg;
        end else if (paddr == `PPFM_OFF_CROLE_HI) begin
            rdata_next[7:0] = cRoleHi_reg;
        end else if (paddr == `PPFM_OFF_DROLE) begin
            rdata_next[7:0] = dRole_reg;
        end else if (paddr == `PPFM_OFF_ROUTE) begin
            rdata_next[7:0] = route_reg;
        end else if (isData) begin
            rdata_next[7:0] = data_reg[portIdx];
        end else if (isDir) begin
            rdata_next[7:0] = dir_reg[portIdx];
        end else if (paddr == `PPFM_OFF_WAKE_EN) begin
            rdata_next[7:0] = wakeEn_reg;
        end else if (paddr == `PPFM_OFF_BITOP) begin
            rdata_next = 32'h0000_0000;
        end else if (paddr == `PPFM_OFF_WAKE_STAT) begin
            rdata_next[7:0] = wakeStat_reg;
        end else begin
            decodeHit = 1'b0;
        end
    end

    // apb answer: one wait-free access phase after every setup
    always @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~decodeHit;
            if (setup & ~pwrite) begin
                prdata <= rdata_next;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // bit operation: whole port read, one bit changed, byte written back
    always @* begin
        bopPort = pwdata[`PPFM_BOP_PORT_LSB +: 2];
        bopMask = 8'h01 << pwdata[`PPFM_BOP_BIT_LSB +: 3];
        if (pwdata[`PPFM_BOP_TGT]) begin
            bopBase = dir_reg[bopPort];
        end else begin
            bopBase = pinsOf(bopPort, portAIn, portBIn, portCIn, portDIn);
        end
        if (pwdata[`PPFM_BOP_VAL]) begin
            bopNew = bopBase | bopMask;
        end else begin
            bopNew = bopBase & ~bopMask;
        end
    end

    // role, routing and wake registers
    always @(posedge clk) begin
        if (rst) begin
            cRoleLo_reg <= `PPFM_RST_ROLE;
            cRoleHi_reg <= `PPFM_RST_ROLE;
            dRole_reg <= `PPFM_RST_ROLE;
            route_reg <= `PPFM_RST_ROUTE;
            wakeEn_reg <= `PPFM_RST_WAKE;
        end else if (wrTake) begin
            if (paddr == `PPFM_OFF_CROLE_LO) begin
                cRoleLo_reg <= wrByte & `PPFM_ROLE_MASK;
            end else if (paddr == `PPFM_OFF_CROLE_HI) begin
                cRoleHi_reg <= wrByte & HI_MASK;
            end else if (paddr == `PPFM_OFF_DROLE) begin
                dRole_reg <= wrByte;
            end else if (paddr == `PPFM_OFF_ROUTE) begin
                route_reg <= wrByte & ROUTE_MASK;
            end else if (paddr == `PPFM_OFF_WAKE_EN) begin
                wakeEn_reg <= wrByte;
            end
        end
    end

    // port data and direction latches, all high after reset
    always @(posedge clk) begin
        if (rst) begin
            data_reg[0] <= `PPFM_RST_PORT;
            data_reg[1] <= `PPFM_RST_PORT;
            data_reg[2] <= `PPFM_RST_PORT;
            data_reg[3] <= `PPFM_RST_PORT;
            dir_reg[0] <= `PPFM_RST_PORT;
            dir_reg[1] <= `PPFM_RST_PORT;
            dir_reg[2] <= `PPFM_RST_PORT;
            dir_reg[3] <= `PPFM_RST_PORT;
        end else if (wrTake) begin
            if (isData) begin
                data_reg[portIdx] <= wrByte;
            end else if (isDir) begin
                dir_reg[portIdx] <= wrByte;
            end else if (paddr == `PPFM_OFF_BITOP) begin
                if (pwdata[`PPFM_BOP_TGT]) begin
                    dir_reg[bopPort] <= bopNew;
                end else begin
                    data_reg[bopPort] <= bopNew;
                end
            end
        end
    end

    // falling edges of enabled port a pins wake the device
    always @* begin
        wakeFall = prevA_reg & ~portAIn & wakeEn_reg;
    end

    // sticky wake flags, write one to clear, a new edge wins over the clear
    always @(posedge clk) begin
        if (rst) begin
            prevA_reg <= `PPFM_RST_PORT;
            wakeStat_reg <= `PPFM_RST_WAKE;
            wakeRequest <= 1'b0;
        end else begin
            prevA_reg <= portAIn;
            wakeRequest <= lowPowerMode & (|wakeFall);
            if (wrTake && paddr == `PPFM_OFF_WAKE_STAT) begin
                wakeStat_reg <= (wakeStat_reg & ~wrByte)
                                | (wakeFall & {8{lowPowerMode}});
            end else begin
                wakeStat_reg <= wakeStat_reg | (wakeFall & {8{lowPowerMode}});
            end
        end
    end

    // role decode for port c pins 0-2 and 4-6; pins 3 and 7 have no role
    always @* begin
        periphEn = 8'h00;
        periphOut = 8'h00;
        periphOe = 8'h00;
        case (roleC0)
            `PPFM_CODE_ALT1: begin
                periphEn[0] = 1'b1;
                periphOut[0] = uartTxOut;
                periphOe[0] = uartTxOe;
            end
            `PPFM_CODE_ALT2: begin
                periphEn[0] = 1'b1;
                periphOut[0] = lcdComSeg[0];
                periphOe[0] = lcdDriveOn;
            end
            `PPFM_CODE_ALT3: begin
                periphEn[0] = 1'b1;
            end
            default: begin
                periphEn[0] = 1'b0;
            end
        endcase
        case (roleC1)
            `PPFM_CODE_ALT1: begin
                periphEn[1] = 1'b1;
                periphOut[1] = uartTxOut;
                periphOe[1] = uartTxOe;
            end
            `PPFM_CODE_ALT2: begin
                periphEn[1] = 1'b1;
                periphOut[1] = lcdComSeg[1];
                periphOe[1] = lcdDriveOn;
            end
            `PPFM_CODE_ALT3: begin
                periphEn[1] = 1'b1;
            end
            default: begin
                periphEn[1] = 1'b0;
            end
        endcase
        case (roleC2)
            `PPFM_CODE_ALT2: begin
                periphEn[2] = 1'b1;
                periphOut[2] = serialDoutOut;
                periphOe[2] = serialDoutOe;
            end
            `PPFM_CODE_ALT3: begin
                periphEn[2] = 1'b1;
                periphOut[2] = lcdComSeg[2];
                periphOe[2] = lcdDriveOn;
            end
            default: begin
                periphEn[2] = 1'b0;
            end
        endcase
        case (roleC4)
            `PPFM_CODE_ALT2: begin
                periphEn[4] = 1'b1;
                periphOut[4] = serialDataOut;
                periphOe[4] = serialDataOe;
            end
            `PPFM_CODE_ALT3: begin
                periphEn[4] = 1'b1;
                periphOut[4] = lcdComSeg[3];
                periphOe[4] = lcdDriveOn;
            end
            default: begin
                periphEn[4] = 1'b0;
            end
        endcase
        case (roleC5)
            `PPFM_CODE_ALT2: begin
                periphEn[5] = 1'b1;
                periphOut[5] = serialClkOut;
                periphOe[5] = serialClkOe;
            end
            `PPFM_CODE_ALT3: begin
                periphEn[5] = 1'b1;
                periphOut[5] = lcdComSeg[4];
                periphOe[5] = lcdDriveOn;
            end
            default: begin
                periphEn[5] = 1'b0;
            end
        endcase
        case (roleC6)
            `PPFM_CODE_ALT2: begin
                periphEn[6] = 1'b1;
                periphOut[6] = serialSelectOut;
                periphOe[6] = serialSelectOe;
            end
            `PPFM_CODE_ALT3: begin
                periphEn[6] = 1'b1;
                periphOut[6] = lcdComSeg[5];
                periphOe[6] = lcdDriveOn;
            end
            default: begin
                periphEn[6] = 1'b0;
            end
        endcase
    end

    // port c pins through one cell each
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : gPortC
            ppfm_pin_cell uCell (
                .clk(clk),
                .rst(rst),
                .gpioOut(data_reg[2][gi]),
                .gpioDirIn(dir_reg[2][gi]),
                .periphEn(periphEn[gi]),
                .periphOut(periphOut[gi]),
                .periphOe(periphOe[gi]),
                .pinOut(portCOut[gi]),
                .pinOe(portCOe[gi])
            );
        end
    endgenerate

    // plain ports a, b and d: data drives, direction high means input
    always @(posedge clk) begin
        if (rst) begin
            portAOut <= `PPFM_RST_PORT;
            portAOe <= 8'h00;
            portBOut <= `PPFM_RST_PORT;
            portBOe <= 8'h00;
            portDOut <= `PPFM_RST_PORT;
            portDOe <= 8'h00;
        end else begin
            portAOut <= data_reg[0];
            portAOe <= ~dir_reg[0];
            portBOut <= data_reg[1];
            portBOe <= ~dir_reg[1];
            portDOut <= data_reg[3];
            portDOe <= ~dir_reg[3];
        end
    end

    // input source routing to peripherals
    always @(posedge clk) begin
        if (rst) begin
            extIrq0 <= 1'b1;
            extIrq1 <= 1'b1;
            serialDinIn <= 1'b1;
            serialClkIn <= 1'b1;
            serialSelectIn <= 1'b1;
            uartRxIn <= 1'b1;
            externalResetInN <= 1'b1;
            crystalPinsSelected <= 1'b0;
        end else begin
            extIrq1 <= route_reg[`PPFM_RT_IRQ1] ? portAIn[2] : portBIn[1];
            extIrq0 <= route_reg[`PPFM_RT_IRQ0] ? portAIn[1] : portBIn[0];
            serialDinIn <= route_reg[`PPFM_RT_SDIN] ? portAIn[3] : portCIn[4];
            serialClkIn <= route_reg[`PPFM_RT_SCLK] ? portBIn[6] : portCIn[5];
            serialSelectIn <= route_reg[`PPFM_RT_SSEL] ? portBIn[5] : portCIn[6];
            uartRxIn <= route_reg[`PPFM_RT_URX] ? portCIn[1] : portDIn[1];
            externalResetInN <= roleC2[1] ? 1'b1 : portCIn[2];
            crystalPinsSelected <= (roleC0 == `PPFM_CODE_ALT3)
                                   | (roleC1 == `PPFM_CODE_ALT3);
        end
    end
endmodule // ppfm_top

// *** tb/ppfm_asserts.sv ***
// concurrent checks on the ports of the port pin function multiplexer
`timescale 1ns/100ps
module ppfm_asserts #(
    parameter LARGE_VARIANT = 1
) (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire [7:0] portAIn,
    input wire [7:0] portBIn,
    input wire [7:0] portCIn,
    input wire [7:0] portDIn,
    input wire [7:0] portDOut,
    input wire [7:0] portDOe,
    input wire lowPowerMode,
    input wire extIrq0,
    input wire extIrq1,
    input wire serialDinIn,
    input wire serialClkIn,
    input wire uartRxIn,
    input wire wakeRequest
);
    reg [5:0] route_reg;
    reg [7:0] wakeEn_reg;
    wire wrDone = psel && penable && pready && pwrite;
    // expected routed inputs from the routing copy and the pin levels
    wire irq1Exp = route_reg[5] ? portAIn[2] : portBIn[1];
    wire irq0Exp = route_reg[4] ? portAIn[1] : portBIn[0];
    wire dinExp = route_reg[3] ? portAIn[3] : portCIn[4];
    wire sclkExp = route_reg[2] ? portBIn[6] : portCIn[5];
    wire rxExp = route_reg[0] ? portCIn[1] : portDIn[1];
    // copies of routing and wake enable, taken from completed writes
    always @(posedge clk) begin
        if (rst) begin
            route_reg <= 6'h00;
            wakeEn_reg <= 8'h00;
        end else if (wrDone && paddr == 8'h0C) begin
            route_reg <= pwdata[5:0] & (LARGE_VARIANT ? 6'h3F : 6'h30);
        end else if (wrDone && paddr == 8'h30) begin
            wakeEn_reg <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence setupPhase;
        psel && !penable;
    endsequence
    sequence portAFall;
        lowPowerMode && (wakeEn_reg & $past(portAIn) & ~portAIn) != 8'h00;
    endsequence
    a_ready_one_cycle: assert property (setupPhase |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    a_irq1_route_sel: assert property (!$past(rst) |-> extIrq1 == $past(irq1Exp))
        else $error("irq1 source wrong");
    a_irq0_route_sel: assert property (!$past(rst) |-> extIrq0 == $past(irq0Exp))
        else $error("irq0 source wrong");
    a_din_route_sel: assert property (!$past(rst) |-> serialDinIn == $past(dinExp))
        else $error("serial data input source wrong");
    a_sclk_route_sel: assert property (!$past(rst) |-> serialClkIn == $past(sclkExp))
        else $error("serial clock input source wrong");
    a_rx_route_sel: assert property (!$past(rst) |-> uartRxIn == $past(rxExp))
        else $error("uart receive source wrong");
    a_role_upper_zero: assert property (psel && penable && pready && !pwrite
        && (paddr == 8'h00 || paddr == 8'h04) |-> prdata[31:6] == 26'h0)
        else $error("role register upper bits not zero");
    a_wake_on_fall: assert property (portAFall |-> ##[1:2] wakeRequest)
        else $error("no wake after enabled pin fell");
    a_reset_port_idle: assert property ($fell(rst) |-> portDOut == 8'hFF && portDOe == 8'h00)
        else $error("port not idle high input after reset");
endmodule // ppfm_asserts

bind ppfm_top ppfm_asserts #(.LARGE_VARIANT(LARGE_VARIANT)) chk_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .portAIn(portAIn), .portBIn(portBIn), .portCIn(portCIn), .portDIn(portDIn),
    .portDOut(portDOut), .portDOe(portDOe), .lowPowerMode(lowPowerMode),
    .extIrq0(extIrq0), .extIrq1(extIrq1), .serialDinIn(serialDinIn),
    .serialClkIn(serialClkIn), .uartRxIn(uartRxIn), .wakeRequest(wakeRequest)
);

// *** tb/ppfm_board.sv ***
// board side of the shared pins: resolves each pin level
`timescale 1ns/100ps
module ppfm_board (
    input wire [31:0] pinOut,
    input wire [31:0] pinOe,
    input wire [31:0] extLevel,
    output wire [31:0] pinLevel
);
    // a driving device output wins, otherwise the board circuit sets the level
    assign pinLevel = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule // ppfm_board

// *** tb/ppfm_bench.sv ***
// self-checking bench for the port pin function multiplexer
`timescale 1ns/100ps
module ppfm_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic lcdOn = 1'b0;
    logic lowPower = 1'b0;
    logic [9:0] per = 10'h000;
    logic [5:0] lcd = 6'h00;
    logic [31:0] ext = 32'h0;
    logic [31:0] prdata, pinLvl, rd, v, rt;
    wire [31:0] pinOut, pinOe;
    logic pready, pslverr, err, irq0, irq1, din, sclk, ssel, urx, rstInN, xtal, wake;
    logic [1:0] e;
    int n_mismatch = 0;
    int cmp_count = 0;
    int i, j, k, c, p;
    always #50 clk = ~clk;
    ppfm_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .portAIn(pinLvl[7:0]), .portBIn(pinLvl[15:8]), .portCIn(pinLvl[23:16]),
        .portDIn(pinLvl[31:24]), .portAOut(pinOut[7:0]), .portAOe(pinOe[7:0]),
        .portBOut(pinOut[15:8]), .portBOe(pinOe[15:8]), .portCOut(pinOut[23:16]),
        .portCOe(pinOe[23:16]), .portDOut(pinOut[31:24]), .portDOe(pinOe[31:24]),
        .uartTxOut(per[0]), .uartTxOe(per[1]), .serialDoutOut(per[2]), .serialDoutOe(per[3]),
        .serialClkOut(per[4]), .serialClkOe(per[5]), .serialDataOut(per[6]),
        .serialDataOe(per[7]), .serialSelectOut(per[8]), .serialSelectOe(per[9]),
        .lcdComSeg(lcd), .lcdDriveOn(lcdOn), .lowPowerMode(lowPower), .extIrq0(irq0),
        .extIrq1(irq1), .serialDinIn(din), .serialClkIn(sclk), .serialSelectIn(ssel),
        .uartRxIn(urx), .externalResetInN(rstInN), .crystalPinsSelected(xtal),
        .wakeRequest(wake));
    ppfm_board brd_u (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext), .pinLevel(pinLvl));
    // verdict and end of run
    task end_of_test;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; read data and error are taken at the pready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            n_mismatch++;
            end_of_test;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task countWake;
        k = 0;
        repeat (4) begin
            @(posedge clk);
            if (wake === 1'b1) k++;
        end
    endtask
    // expected {enable, value} of a port c pin for a role code
    function automatic logic [1:0] expPin(int q, logic [1:0] r, logic d, logic dirIn);
        logic [1:0] pd [6];
        pd = '{per[1:0], per[1:0], per[3:2], per[7:6], per[5:4], per[9:8]};
        if (q < 2 && r == 2'h3) return 2'b00;
        if (r == (q < 2 ? 2'h2 : 2'h3)) return {lcdOn, lcd[q]};
        if (r == (q < 2 ? 2'h1 : 2'h2)) return pd[q];
        return {~dirIn, d};
    endfunction
    // main sequence
    initial begin
        void'($urandom(32'hBE4B9CA3));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        chk(pinOe, 32'h0);
        chk(pinOut, 32'hFFFFFFFF);
        for (i = 0; i < 8; i++) rdchk(8'h10 + 8'(4 * i), 32'hFF);
        wr(8'h00, 32'hFFFFFFFF);
        rdchk(8'h00, 32'h3F);
        chk(err, 1'b0);
        wr(8'h04, 32'hFFFFFFC0);
        rdchk(8'h04, 32'h00);
        wr(8'h08, 32'hA5);
        rdchk(8'h08, 32'hA5);
        apb(1'b0, 8'h3C, 32'h0);
        chk(err, 1'b1);
        wr(8'h2C, 32'h00);
        settle(2);
        chk({pinOe[31:24], pinOut[31:24]}, 16'hFFFF);
        wr(8'h2C, 32'hFF);
        v = $urandom;
        wr(8'h18, v[7:0]);
        wr(8'h28, v[15:8]);
        for (c = 0; c < 4; c++) begin
            @(posedge clk);
            per <= 10'($urandom);
            lcd <= 6'($urandom);
            lcdOn <= 1'($urandom);
            wr(8'h00, {c[1:0], c[1:0], c[1:0]});
            wr(8'h04, {c[1:0], c[1:0], c[1:0]});
            settle(3);
            for (p = 0; p < 6; p++) begin
                k = (p < 3) ? p : p + 1;
                e = expPin(p, c[1:0], v[k], v[8 + k]);
                chk({pinOe[16 + k], pinOut[16 + k] & pinOe[16 + k]}, {e[1], e[1] & e[0]});
            end
            chk(xtal, c == 3);
            chk(rstInN, c < 2 ? (v[10] ? ext[18] : v[2]) : 1'b1);
        end
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h28, 32'hFF);
        for (i = 0; i < 8; i++) begin
            rt = (i == 0) ? 32'h0 : (i == 1) ? 32'h3F : $urandom;
            @(posedge clk);
            ext <= $urandom;
            wr(8'h0C, rt);
            settle(3);
            chk(irq1, rt[5] ? ext[2] : ext[9]);
            chk(irq0, rt[4] ? ext[1] : ext[8]);
            chk(din, rt[3] ? ext[3] : ext[20]);
            chk(sclk, rt[2] ? ext[14] : ext[21]);
            chk(ssel, rt[1] ? ext[13] : ext[22]);
            chk(urx, rt[0] ? ext[17] : ext[25]);
        end
        @(posedge clk);
        ext <= $urandom;
        k = $urandom_range(7, 0);
        settle(3);
        wr(8'h34, 32'h42 | (k << 2));
        rdchk(8'h18, ext[23:16] | (8'h01 << k));
        wr(8'h34, 32'h22 | (k << 2));
        rdchk(8'h28, 8'hFF & ~(8'h01 << k));
        j = $urandom_range(7, 0);
        @(posedge clk);
        ext[7:0] <= 8'hFF;
        lowPower <= 1'b1;
        wr(8'h30, 32'h1 << j);
        settle(2);
        @(posedge clk);
        ext[(j + 1) % 8] <= 1'b0;
        countWake;
        chk(k, 0);
        @(posedge clk);
        ext[j] <= 1'b0;
        countWake;
        chk(k > 0, 1'b1);
        rdchk(8'h38, 32'h1 << j);
        wr(8'h38, 32'hFF);
        rdchk(8'h38, 32'h0);
        end_of_test;
    end
endmodule // ppfm_bench
